// file: rtl/mxp_pkg.sv
/*
  Package for the repeater MII expansion port: speed encoding, clock divider
  constants and the packed carriers between the repeater core and the port.
  Assumes a single 20 MHz system clock, mclk, runs the whole port.
*/
package mxp_pkg;

  // System clock and MII clock rates, in kHz
  localparam int unsigned SYS_CLK_KHZ = 20000;
  localparam int unsigned MII_FAST_KHZ = 25000;
  localparam int unsigned MII_SLOW_KHZ = 2500;

  // Half periods of the sourced MII clock in mclk cycles, rounded down, at least one
  localparam int unsigned HALF_FAST_RAW = SYS_CLK_KHZ / (2 * MII_FAST_KHZ);
  localparam int unsigned HALF_SLOW_RAW = SYS_CLK_KHZ / (2 * MII_SLOW_KHZ);
  localparam int unsigned HALF_FAST = (HALF_FAST_RAW < 1) ? 1 : HALF_FAST_RAW;
  localparam int unsigned HALF_SLOW = (HALF_SLOW_RAW < 1) ? 1 : HALF_SLOW_RAW;

  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] HALF_FAST_CNT = DIV_W'(HALF_FAST - 1);
  localparam logic [DIV_W-1:0] HALF_SLOW_CNT = DIV_W'(HALF_SLOW - 1);
  localparam logic [DIV_W-1:0] DIV_RESET = 4'h0;

  // Speed selection as caught from the strap
  typedef enum logic
  {
    MXP_SPEED_10 = 1'b0,
    MXP_SPEED_100 = 1'b1
  } mxp_speed_e;

  // Strap capture sequencer
  typedef enum logic [1:0]
  {
    MXP_ST_SYNC = 2'b00,
    MXP_ST_FILL = 2'b01,
    MXP_ST_LATCH = 2'b11,
    MXP_ST_RUN = 2'b10
  } mxp_state_e;

  localparam logic [3:0] NIBBLE_ZERO = 4'h0;

  // Repeated receive stream from the repeater core toward the MAC
  typedef struct packed
  {
    logic [3:0] data;
    logic valid;
    logic error;
    logic collision;
    logic carrier;
  } mxp_rx_s;

  // Transmit stream from the MAC toward the repeater core
  typedef struct packed
  {
    logic [3:0] data;
    logic valid;
    logic error;
    logic invalid_symbol;
  } mxp_tx_s;

endpackage : mxp_pkg

// file: rtl/mxp_port.sv
/*
  MII expansion port of the repeater, device side. Sources the MII receive and
  transmit clocks from mclk, presents repeated data toward the MAC and captures
  the MAC's transmit nibbles. Assumes the core stream is on mclk and that the
  MAC's pins are asynchronous to mclk, so they pass two flip-flops first.
*/
// Functional notes
// - Strap sampled at every reset; high means 100 Mbps, low means 10 Mbps.
// - Receive nibble toward MAC changes on falling edge of sourced receive clock.
// - Receive valid high, synchronous to receive clock, while nibble is valid.
// - Receive error high, synchronous to receive clock, when nibble is invalid.
// - Receive and transmit clocks sourced as 2.5 or 25 MHz outputs; at 20 MHz mclk the fast rate is 10 MHz (mclk / 2).
// - Transmit error honoured only at 100 Mbps; invalid symbols replace data.
// - Transmit nibble captured on rising transmit clock edge while enable high.
// - Collision output high whenever the repeater sees a collision.
// - Carrier sense high while transmitting toward or receiving from this port.
`timescale 1ns/10ps
module mxp_port
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic soft_reset,
  // Strap
  input wire logic port_speed_strap,
  // Repeater core side
  input wire mxp_pkg::mxp_rx_s core_rx,
  output mxp_pkg::mxp_tx_s core_tx,
  output mxp_pkg::mxp_speed_e port_speed,
  // MII pins
  output logic port_receive_clock,
  output logic port_transmit_clock,
  output logic [3:0] port_receive_data,
  output logic port_receive_valid,
  output logic port_receive_error,
  output logic port_collision,
  output logic port_carrier_sense,
  input wire logic [3:0] port_transmit_data,
  input wire logic port_transmit_enable,
  input wire logic port_transmit_error
);

  // Two-flop synchronisers for all asynchronous pins
  localparam int SYNC_W = 7;
  logic [SYNC_W-1:0] sync1_reg, sync2_reg, sync1_next, sync2_next;

  // Strap sequencer and speed
  mxp_pkg::mxp_state_e state_reg, state_next;
  mxp_pkg::mxp_speed_e speed_reg, speed_next;

  // Clock divider
  logic [mxp_pkg::DIV_W-1:0] div_reg, div_next;
  logic clk_reg, clk_next;
  logic rise_en, fall_en;

  // Output registers
  mxp_pkg::mxp_rx_s rx_reg, rx_next;
  mxp_pkg::mxp_tx_s tx_reg, tx_next;

  logic [3:0] tx_data_s;
  logic tx_en_s, tx_er_s, strap_s;

  assign tx_data_s = sync2_reg[3:0];
  assign tx_en_s = sync2_reg[4];
  assign tx_er_s = sync2_reg[5];
  assign strap_s = sync2_reg[6];

  always_comb
  begin
    sync1_next = {port_speed_strap, port_transmit_error, port_transmit_enable, port_transmit_data};
    sync2_next = sync1_reg;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // Strap is caught after the hardware reset release and after a software reset;
  // SYNC and FILL let both synchroniser stages fill with the true pin level first,
  // since the second stage still holds its reset value one edge after release.
  always_comb
  begin
    state_next = state_reg;
    speed_next = speed_reg;
    case (state_reg)
      mxp_pkg::MXP_ST_SYNC:
        state_next = mxp_pkg::MXP_ST_FILL;
      mxp_pkg::MXP_ST_FILL:
        state_next = mxp_pkg::MXP_ST_LATCH;
      mxp_pkg::MXP_ST_LATCH:
      begin
        speed_next = strap_s ? mxp_pkg::MXP_SPEED_100 : mxp_pkg::MXP_SPEED_10;
        state_next = mxp_pkg::MXP_ST_RUN;
      end
      mxp_pkg::MXP_ST_RUN:
        state_next = mxp_pkg::MXP_ST_RUN;
      default:
        state_next = mxp_pkg::MXP_ST_SYNC;
    endcase
    if (soft_reset)
    begin
      state_next = mxp_pkg::MXP_ST_SYNC;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= mxp_pkg::MXP_ST_SYNC;
      speed_reg <= mxp_pkg::MXP_SPEED_10;
    end
    else
    begin
      state_reg <= state_next;
      speed_reg <= speed_next;
    end
  end

  // Clock divider: both MII clocks share one phase. At 20 MHz mclk the fast rate
  // cannot reach 25 MHz; it runs at the highest rate mclk allows (mclk / 2).
  always_comb
  begin
    logic [mxp_pkg::DIV_W-1:0] half;
    half = (speed_reg == mxp_pkg::MXP_SPEED_100) ? mxp_pkg::HALF_FAST_CNT : mxp_pkg::HALF_SLOW_CNT;
    div_next = div_reg;
    clk_next = clk_reg;
    rise_en = 1'b0;
    fall_en = 1'b0;
    if (state_reg != mxp_pkg::MXP_ST_RUN)
    begin
      div_next = mxp_pkg::DIV_RESET;
      clk_next = 1'b0;
    end
    else if (div_reg >= half)
    begin
      div_next = mxp_pkg::DIV_RESET;
      clk_next = ~clk_reg;
      rise_en = ~clk_reg;
      fall_en = clk_reg;
    end
    else
    begin
      div_next = div_reg + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_reg <= mxp_pkg::DIV_RESET;
      clk_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      clk_reg <= clk_next;
    end
  end

  // Receive side: everything toward the MAC changes at the falling edge
  always_comb
  begin
    rx_next = rx_reg;
    if (fall_en)
    begin
      rx_next.data = core_rx.valid ? core_rx.data : mxp_pkg::NIBBLE_ZERO;
      rx_next.valid = core_rx.valid;
      rx_next.error = core_rx.valid & core_rx.error;
      rx_next.collision = core_rx.collision;
      // Carrier covers both directions of this port
      rx_next.carrier = core_rx.carrier | core_rx.valid | tx_en_s;
    end
  end

  // Transmit side: sampled at the rising edge the MAC sees. The pins pass the
  // synchroniser, so this sees the MAC's nibble two mclk cycles late; the MAC
  // launches on the falling edge, which covers that at 10 Mbps; at 100 Mbps each rise takes the nibble launched one clock earlier.
  always_comb
  begin
    tx_next = tx_reg;
    if (rise_en)
    begin
      tx_next.valid = tx_en_s;
      tx_next.data = tx_en_s ? tx_data_s : mxp_pkg::NIBBLE_ZERO;
      tx_next.error = tx_en_s & tx_er_s;
      // Error only counts in 100 Mbps mode; the core then sends invalid code symbols
      tx_next.invalid_symbol = tx_en_s & tx_er_s & (speed_reg == mxp_pkg::MXP_SPEED_100);
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_reg <= '0;
      tx_reg <= '0;
    end
    else
    begin
      rx_reg <= rx_next;
      tx_reg <= tx_next;
    end
  end

  // An unused port has enable grounded, so tx_reg simply stays idle
  assign port_receive_clock = clk_reg;
  assign port_transmit_clock = clk_reg;
  assign port_receive_data = rx_reg.data;
  assign port_receive_valid = rx_reg.valid;
  assign port_receive_error = rx_reg.error;
  assign port_collision = rx_reg.collision;
  assign port_carrier_sense = rx_reg.carrier;
  assign core_tx = tx_reg;
  assign port_speed = speed_reg;

endmodule : mxp_port

// file: verif/mxp_port_props.sv
/* Checker for the MII expansion port.
   Assumes it is bound to mxp_port and sees only its ports. */
`timescale 1ns/10ps
module mxp_port_props
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic soft_reset,
  // Watched outputs
  input wire mxp_pkg::mxp_tx_s core_tx,
  input wire mxp_pkg::mxp_speed_e port_speed,
  input wire logic port_receive_clock,
  input wire logic port_transmit_clock,
  input wire logic [3:0] port_receive_data,
  input wire logic port_receive_valid,
  input wire logic port_receive_error,
  input wire logic port_collision,
  input wire logic port_carrier_sense
);
  default clocking @(posedge mclk);
  endclocking
  // Soft reset restarts strap capture and stops the clocks, so checks pause with it
  default disable iff (!reset_n || soft_reset);
  property p_rxe; $changed({port_receive_data, port_receive_valid, port_receive_error, port_collision,
    port_carrier_sense}) |-> $fell(port_receive_clock); endproperty
  a_rxe: assert property (p_rxe) else $error("rx moved off fall");
  property p_err; port_receive_error |-> port_receive_valid; endproperty
  a_err: assert property (p_err) else $error("rx error without valid");
  property p_clk; port_receive_clock == port_transmit_clock; endproperty
  a_clk: assert property (p_clk) else $error("clocks differ");
  property p_fast; port_speed && port_receive_clock |=> !port_receive_clock; endproperty
  a_fast: assert property (p_fast) else $error("fast clock shape");
  property p_slow; !port_speed && $rose(port_receive_clock) |-> port_receive_clock[*4] ##1 !port_receive_clock; endproperty
  a_slow: assert property (p_slow) else $error("slow clock shape");
  property p_hold; $past(port_receive_clock) |-> $stable(port_speed); endproperty
  a_hold: assert property (p_hold) else $error("speed moved");
  property p_txe; $changed(core_tx) |-> $rose(port_transmit_clock); endproperty
  a_txe: assert property (p_txe) else $error("tx capture off rise");
  property p_inv; core_tx.invalid_symbol |-> port_speed; endproperty
  a_inv: assert property (p_inv) else $error("tx error at 10");
endmodule : mxp_port_props
bind mxp_port mxp_port_props u_props (.*);

// file: verif/mxp_mac_model.sv
/* Behavioural MAC on the port's transmit pins.
   Assumes the bench sets the next nibble between falling clock edges. */
`timescale 1ns/10ps
module mxp_mac_model
(
  // Port clock and bench request
  input wire logic tx_clk,
  input wire logic [3:0] nib,
  input wire logic en,
  input wire logic er,
  // MII pins
  output logic [3:0] txd = 4'h0,
  output logic txen = 1'b0,
  output logic txer = 1'b0
);
  // Pins move after the fall so they are settled for the rise
  always @(negedge tx_clk)
  begin
    txen <= en;
    txer <= en & er;
    // Idle data lines carry no meaning, so they keep changing
    txd <= en ? nib : ~txd;
  end
endmodule : mxp_mac_model

// file: verif/mxp_port_tb_top.sv
/* Bench for mxp_port: core stream in, MAC model on the pins, queued expectations.
   Assumes only the 20 MHz mclk around the port. */
`timescale 1ns/10ps
module mxp_port_tb_top;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic soft_reset = 1'b0;
  logic strap = 1'b1;
  logic [3:0] nib = 4'h0;
  logic en = 1'b0;
  logic er = 1'b0;
  logic [31:0] seed = 32'hD1C5;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  mxp_pkg::mxp_rx_s rx = '0;
  mxp_pkg::mxp_tx_s ctx;
  mxp_pkg::mxp_speed_e spd;
  logic rxc, txc, rxv, rxe, col, crs, txen, txer;
  logic [3:0] rxd, txd;
  logic [7:0] rq[$];
  logic [6:0] tq[$];
  mxp_port dut (.mclk(mclk), .reset_n(reset_n), .soft_reset(soft_reset), .port_speed_strap(strap), .core_rx(rx),
    .core_tx(ctx), .port_speed(spd), .port_receive_clock(rxc), .port_transmit_clock(txc), .port_receive_data(rxd),
    .port_receive_valid(rxv), .port_receive_error(rxe), .port_collision(col), .port_carrier_sense(crs),
    .port_transmit_data(txd), .port_transmit_enable(txen), .port_transmit_error(txer));
  mxp_mac_model mac (.tx_clk(txc), .nib(nib), .en(en), .er(er), .txd(txd), .txen(txen), .txer(txer));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  always @(negedge rxc)
  begin
    #1;
    if (rq.size() > 0)
      check({rxd, rxv, rxe, col, crs}, rq.pop_front());
  end
  always @(posedge txc)
  begin
    #1;
    if (ctx.valid === 1'b1)
      check({1'b0, ctx.data, ctx.valid, ctx.error, ctx.invalid_symbol}, {1'b0, tq.pop_front()});
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    #2 reset_n = 1'b1;
    // Strap high through the hardware reset: the port must come up at 100
    repeat (6) @(posedge mclk);
    #2 check({7'h0, spd}, 8'h01);
    for (int m = 1; m >= 0; m--)
    begin
      strap = m[0];
      soft_reset = 1'b1;
      repeat (3) @(posedge mclk);
      #2 soft_reset = 1'b0;
      repeat (6) @(posedge mclk);
      #2 check({7'h0, spd}, {7'h0, m[0]});
      // Last two nibbles are all zero so the outputs are quiet before the next soft reset
      for (int i = 0; i < 13; i++)
      begin
        @(negedge rxc);
        #2 seed = lfsr(seed);
        rx = (i > 10) ? '0 : seed[7:0];
        rq.push_back({rx.valid ? rx.data : 4'h0, rx.valid, rx.valid & rx.error, rx.collision, rx.carrier | rx.valid});
      end
      for (int i = 0; i < 16; i++)
      begin
        @(posedge txc);
        #2 seed = lfsr(seed);
        en = (i < 12);
        nib = seed[3:0];
        er = seed[4];
        if (en)
          tq.push_back({nib, 1'b1, er, er & m[0]});
        if (i == 6)
          check({7'h0, crs}, 8'h01);
      end
    end
    // Every queued nibble must have shown up exactly once
    check(8'(rq.size() + tq.size()), 8'h00);
    end_of_test();
  end
endmodule : mxp_port_tb_top
